// ===== rtl/tfc_pkg.sv
package tfc_pkg;

  // ----------------------------------------------------------------
  // Clock and sample rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int RATE_48_HZ  = 48000;
  localparam int RATE_441_HZ = 44100;
  localparam int DIV_W       = 12;
  localparam logic [DIV_W-1:0] DIV_48  = DIV_W'(CLK_HZ / RATE_48_HZ - 1);
  localparam logic [DIV_W-1:0] DIV_441 = DIV_W'(CLK_HZ / RATE_441_HZ - 1);

  // ----------------------------------------------------------------
  // Format timing
  // ----------------------------------------------------------------
  localparam int LEAD_SEC    = 15;
  localparam int DATA_SEC    = 120;
  localparam int PREROLL_SEC = 5;
  localparam int SPINUP_MS   = 500;
  localparam int SPINUP_CYC  = CLK_HZ / 1000 * SPINUP_MS;
  localparam logic [15:0] BLINK_SAMPLES = 16'h2EE0;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STAT   = 4'h4;
  localparam logic [3:0] ADDR_TC     = 4'h8;
  localparam int         CTRL_RATE   = 0;
  localparam int         STAT_ARMED  = 3;
  localparam int         STAT_PROT   = 4;
  localparam int         STAT_OVR    = 5;
  localparam int         STAT_FS     = 6;
  localparam int         STAT_BLOCK  = 8;
  localparam logic       CTRL_RESET  = 1'h0;

  // ----------------------------------------------------------------
  // Section codes on the write head
  // ----------------------------------------------------------------
  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_LEAD = 2'h1;
  localparam logic [1:0] SEC_DATA = 2'h2;
  localparam logic [1:0] SEC_TIME = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_SPINUP, ST_REW_BOT, ST_REW_FO,
    ST_LEADER, ST_DATA, ST_TIMEREF
  } tfc_state_t;

endpackage

// ===== rtl/tfc_rate_div.sv
`timescale 1ns/1ns
module tfc_rate_div
  import tfc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sel_441_i,
  output logic      tick_o
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] top;

  assign top = sel_441_i ? DIV_441 : DIV_48;

  // ----------------------------------------------------------------
  // One pulse per sample period
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_r >= top) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r >= top);
    end
  end

endmodule

// ===== rtl/tfc_top.sv
// Contract
// - Record with format armed first plays briefly to reach speed and check.
// - Complete format writes leader, data, then time from minus five seconds.
// - Unformatted tape off start rewinds; found formatting halts there, armed.
// - Formatted tape before time zero rewinds then formats completely.
// - Forced reformat rewind shows reformat code and flashes rewind light.
// - Formatted tape past time zero formats from the current position.
// - Extension continues time stamps from last valid stamp read.
// - Extend reads tape time after playback and formats onward from it.
// - Format key lights format steadily and flashes all eight armed lights.
// - Per-track arming keys are ignored while formatting is armed.
// - Pre-armed tracks take input audio but write only from time zero.
// - Unarmed tracks receive silence during formatting.
// - Only stop ends formatting; punch-out does not. The code also ends it on tape removal, and at end of tape while writing the time section.
// - Formatting overwrites all eight tracks.
// - Data section carries rate, 48 or 44.1 kHz; time counts samples.
// - Missing tab, sensed at insertion, blocks recording and lights protect.
// - Set-locate plus track one arm key toggles the protect override.
// - Footswitch idle level learnt at power-up decides press sense.
// - Override clears on eject or power loss.
`timescale 1ns/1ns
module tfc_top
  import tfc_pkg::*;
#(
  parameter int SPS_48      = RATE_48_HZ,
  parameter int SPS_441     = RATE_441_HZ,
  parameter int SPINUP_CYCS = SPINUP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        format_key_i,
  input  wire logic        record_play_i,
  input  wire logic        play_key_i,
  input  wire logic        stop_key_i,
  input  wire logic        punch_out_i,
  input  wire logic        set_locate_i,
  input  wire logic [7:0]  track_arm_key_i,
  input  wire logic        tape_present_i,
  input  wire logic        tape_tab_i,
  input  wire logic        tape_formatted_i,
  input  wire logic        tape_at_bot_i,
  input  wire logic        tape_at_eot_i,
  input  wire logic        tape_tc_valid_i,
  input  wire logic [31:0] tape_tc_i,
  input  wire logic [1:0]  transport_footswitch_input_i,
  output logic      [1:0]  footswitch_press_o,
  output logic             xport_play_o,
  output logic             xport_rew_o,
  output logic             xport_rec_o,
  output logic      [1:0]  wr_section_o,
  output logic      [31:0] wr_tc_o,
  output logic             wr_rate_441_o,
  output logic      [7:0]  trk_overwrite_o,
  output logic      [7:0]  trk_audio_en_o,
  output logic      [7:0]  track_armed_led_o,
  output logic             format_led_o,
  output logic             protect_led_o,
  output logic             rew_led_o,
  output logic             reformat_display_code_o
);

  tfc_state_t         st_r;
  tfc_state_t         st_nxt;
  logic               rate_441_r;
  logic               ack_r;
  logic        [31:0] rdat_r;
  logic signed [31:0] tc_r;
  logic        [31:0] samp_cnt_r;
  logic        [31:0] spin_cnt_r;
  logic        [15:0] blink_cnt_r;
  logic               blink_r;
  logic        [7:0]  trk_arm_r;
  logic               prot_r;
  logic               ovr_r;
  logic               tape_prev_r;
  logic        [1:0]  fs_idle_r;
  logic               fs_seen_r;
  logic               samp_tick;
  logic               blocked;
  logic               fmt_armed;
  logic               spin_done;
  logic               sec_done;
  logic               wb_req;
  logic               ovr_key;
  logic        [31:0] sps;
  logic        [31:0] lead_len;
  logic        [31:0] data_len;
  logic        [31:0] tc_start;

  tfc_rate_div u_div (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_441_i (rate_441_r),
    .tick_o    (samp_tick)
  );

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  assign sps       = rate_441_r ? 32'(SPS_441) : 32'(SPS_48);
  assign lead_len  = 32'(LEAD_SEC) * sps;
  assign data_len  = 32'(DATA_SEC) * sps;
  assign tc_start  = 32'(0) - 32'(PREROLL_SEC) * sps;
  assign blocked   = prot_r && !ovr_r;
  assign fmt_armed = (st_r != ST_IDLE);
  assign spin_done = (spin_cnt_r >= 32'(SPINUP_CYCS));
  assign wb_req    = wb_cyc_i && wb_stb_i && !ack_r;
  assign ovr_key   = set_locate_i && track_arm_key_i[0];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_441_r <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL
                 && st_r == ST_IDLE) begin
      rate_441_r <= wb_dat_i[CTRL_RATE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (wb_req) begin
      rdat_r <= '0;
      unique case (wb_adr_i)
        ADDR_CTRL: rdat_r[CTRL_RATE] <= rate_441_r;
        ADDR_STAT: begin
          rdat_r[2:0]               <= st_r;
          rdat_r[STAT_ARMED]        <= fmt_armed;
          rdat_r[STAT_PROT]         <= prot_r;
          rdat_r[STAT_OVR]          <= ovr_r;
          rdat_r[STAT_FS+1:STAT_FS] <= fs_idle_r;
          rdat_r[STAT_BLOCK]        <= blocked;
        end
        ADDR_TC:   rdat_r <= tc_r;
        default:   rdat_r <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Format sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (format_key_i && tape_present_i && !blocked) begin
          st_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (format_key_i) begin
          st_nxt = ST_IDLE;
        end else if ((record_play_i || play_key_i) && !blocked) begin
          st_nxt = ST_SPINUP;
        end
      end
      ST_SPINUP: begin
        if (spin_done) begin
          if (!tape_formatted_i) begin
            st_nxt = tape_at_bot_i ? ST_LEADER : ST_REW_BOT;
          end else if (tape_tc_valid_i && !tape_tc_i[31]) begin
            st_nxt = ST_TIMEREF;
          end else begin
            st_nxt = ST_REW_FO;
          end
        end
      end
      ST_REW_BOT: begin
        if (tape_formatted_i) begin
          st_nxt = ST_ARMED;
        end else if (tape_at_bot_i) begin
          st_nxt = ST_LEADER;
        end
      end
      ST_REW_FO: begin
        if (tape_at_bot_i) begin
          st_nxt = ST_LEADER;
        end
      end
      ST_LEADER: begin
        if (sec_done) begin
          st_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (sec_done) begin
          st_nxt = ST_TIMEREF;
        end
      end
      ST_TIMEREF: begin
        if (tape_at_eot_i) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
    if (stop_key_i || !tape_present_i) begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || st_r != ST_SPINUP) begin
      spin_cnt_r <= '0;
    end else if (!spin_done) begin
      spin_cnt_r <= spin_cnt_r + 32'(1);
    end
  end

  assign sec_done = samp_tick &&
                    (samp_cnt_r + 32'(1) >=
                     ((st_r == ST_LEADER) ? lead_len : data_len));

  always_ff @(posedge clk_i) begin
    if (rst_i || st_nxt != st_r) begin
      samp_cnt_r <= '0;
    end else if (samp_tick) begin
      samp_cnt_r <= samp_cnt_r + 32'(1);
    end
  end

  // ----------------------------------------------------------------
  // Time reference
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_r <= '0;
    end else if (st_r == ST_SPINUP && st_nxt == ST_TIMEREF) begin
      tc_r <= tape_tc_i;
    end else if (st_r == ST_DATA && st_nxt == ST_TIMEREF) begin
      tc_r <= tc_start;
    end else if (st_r == ST_TIMEREF && samp_tick) begin
      tc_r <= tc_r + 32'sd1;
    end
  end

  // ----------------------------------------------------------------
  // Write protect and override
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tape_prev_r <= 1'b0;
    end else begin
      tape_prev_r <= tape_present_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !tape_present_i) begin
      prot_r <= 1'b0;
    end else if (!tape_prev_r) begin
      prot_r <= !tape_tab_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !tape_present_i) begin
      ovr_r <= 1'b0;
    end else if (ovr_key) begin
      ovr_r <= !ovr_r;
    end
  end

  // ----------------------------------------------------------------
  // Track arming and indicators
  // ----------------------------------------------------------------
  // keys ignored while armed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trk_arm_r <= '0;
    end else if (!fmt_armed && !set_locate_i) begin
      trk_arm_r <= trk_arm_r ^ track_arm_key_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (samp_tick) begin
      if (blink_cnt_r >= BLINK_SAMPLES) begin
        blink_cnt_r <= '0;
        blink_r     <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 16'h0001;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_trk
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          track_armed_led_o[g] <= 1'b0;
          trk_audio_en_o[g]    <= 1'b0;
        end else begin
          track_armed_led_o[g] <= (fmt_armed || trk_arm_r[g]) && blink_r;
          trk_audio_en_o[g]    <= trk_arm_r[g] && st_r == ST_TIMEREF &&
                                  !tc_r[31];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      format_led_o            <= 1'b0;
      protect_led_o           <= 1'b0;
      rew_led_o               <= 1'b0;
      reformat_display_code_o <= 1'b0;
    end else begin
      format_led_o  <= fmt_armed ||
                       (tape_present_i && !tape_formatted_i && blink_r);
      protect_led_o <= blocked;
      reformat_display_code_o <= (st_r == ST_REW_FO);
      rew_led_o     <= (st_r == ST_REW_BOT) ||
                       (st_r == ST_REW_FO && blink_r);
    end
  end

  // ----------------------------------------------------------------
  // Transport and head outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xport_play_o    <= 1'b0;
      xport_rew_o     <= 1'b0;
      xport_rec_o     <= 1'b0;
      wr_section_o    <= SEC_NONE;
      wr_tc_o         <= '0;
      wr_rate_441_o   <= 1'b0;
      trk_overwrite_o <= '0;
    end else begin
      xport_play_o  <= st_r inside {ST_SPINUP, ST_LEADER, ST_DATA,
                                    ST_TIMEREF};
      xport_rew_o   <= st_r inside {ST_REW_BOT, ST_REW_FO};
      xport_rec_o   <= st_r inside {ST_LEADER, ST_DATA, ST_TIMEREF};
      trk_overwrite_o <= {8{st_r inside {ST_LEADER, ST_DATA, ST_TIMEREF}}};
      unique case (st_r)
        ST_LEADER:  wr_section_o <= SEC_LEAD;
        ST_DATA:    wr_section_o <= SEC_DATA;
        ST_TIMEREF: wr_section_o <= SEC_TIME;
        default:    wr_section_o <= SEC_NONE;
      endcase
      wr_rate_441_o <= rate_441_r;
      wr_tc_o       <= tc_r;
    end
  end

  // ----------------------------------------------------------------
  // Footswitch polarity
  // ----------------------------------------------------------------
  // learn idle level once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_seen_r <= 1'b0;
      fs_idle_r <= '0;
    end else if (!fs_seen_r) begin
      fs_seen_r <= 1'b1;
      fs_idle_r <= transport_footswitch_input_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      footswitch_press_o <= '0;
    end else begin
      footswitch_press_o <= fs_seen_r ?
                            (transport_footswitch_input_i ^ fs_idle_r) : '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_spinup_first: assert property (
    st_r == ST_ARMED && record_play_i && !format_key_i && !blocked &&
    !stop_key_i && tape_present_i |=> st_r == ST_SPINUP)
    else $error("record did not start spin-up");
  a_stop_ends: assert property (
    stop_key_i && st_r != ST_IDLE |=> st_r == ST_IDLE ##1 !xport_rec_o)
    else $error("stop did not end formatting");
  a_punch_kept: assert property (
    st_r == ST_TIMEREF && punch_out_i && !stop_key_i && tape_present_i &&
    !tape_at_eot_i |=> st_r == ST_TIMEREF)
    else $error("punch-out ended format");
  a_arm_frozen: assert property (
    fmt_armed |=> $stable(trk_arm_r))
    else $error("track arm changed while armed");
  a_fo_code: assert property (
    st_r == ST_REW_FO |=> reformat_display_code_o && xport_rew_o)
    else $error("reformat code missing");
  a_audio_zero: assert property (
    |trk_audio_en_o |-> !$past(tc_r[31]) &&
    (trk_audio_en_o & ~$past(trk_arm_r)) == 8'h00)
    else $error("audio written early or on safe track");
  a_tc_step: assert property (
    st_r == ST_TIMEREF && st_nxt == ST_TIMEREF && samp_tick
    |=> tc_r == $past(tc_r) + 32'sd1)
    else $error("time reference did not step");
  a_extend_load: assert property (
    st_r == ST_SPINUP && st_nxt == ST_TIMEREF
    |=> tc_r == $past(tape_tc_i) ##1 wr_section_o == SEC_TIME)
    else $error("extend did not load tape time");
  a_protect_blk: assert property (
    st_r == ST_IDLE && blocked |=> st_r == ST_IDLE)
    else $error("protected tape armed");
  a_ovr_clear: assert property (
    !tape_present_i |=> !ovr_r [*2])
    else $error("override kept after eject");

  c_complete: cover property (st_r == ST_DATA ##1 st_r == ST_TIMEREF);
  c_extend: cover property (st_r == ST_SPINUP ##1 st_r == ST_TIMEREF);
  c_reformat: cover property (st_r == ST_REW_FO ##1 st_r == ST_LEADER);
  c_halt: cover property (st_r == ST_REW_BOT ##1 st_r == ST_ARMED);

endmodule

// ===== verification/tfc_tape_model.sv
`timescale 1ns/1ns
// Tape transport: rewinds a step a clock, plays a step per 256 clocks
module tfc_tape_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        play_i,
  input  wire logic        rew_i,
  input  wire logic        rec_i,
  input  wire logic        ld_i,
  input  wire logic [31:0] ld_pos_i,
  input  wire logic [31:0] fmt_lo_i,
  input  wire logic [31:0] fmt_hi_i,
  input  wire logic [31:0] zero_i,
  output logic             fmt_o,
  output logic             bot_o,
  output logic      [31:0] tc_o
);
  logic [31:0] pos_r;
  logic [7:0]  pre_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk_i) begin
    cnt_r <= cnt_r + 32'h1;
    if (rst_i) begin
      cnt_r <= 32'h0;
      pos_r <= 32'h0;
      pre_r <= 8'h0;
    end else if (ld_i) begin
      pos_r <= ld_pos_i;
      pre_r <= 8'h0;
    end else if (rew_i) begin
      if (pos_r != 32'h0) pos_r <= pos_r - 32'h1;
      pre_r <= 8'h0;
    end else if (play_i | rec_i) begin
      pre_r <= pre_r + 8'h1;
      if (&pre_r) pos_r <= pos_r + 32'h1;
    end else begin
      pre_r <= 8'h0;
    end
  end

  assign fmt_o = (pos_r >= fmt_lo_i) && (pos_r < fmt_hi_i);
  assign bot_o = (pos_r == 32'h0);
  // Unformatted tape gives a time value that never holds still
  assign tc_o  = fmt_o ? pos_r - zero_i : ~cnt_r;
endmodule

// ===== verification/tfc_top_test.sv
`timescale 1ns/1ns
module tfc_top_test;
  import tfc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wtc, ttc, ld_pos = 32'h0;
  logic [31:0] lo = 32'h0, hi = 32'h0, zero = 32'h0;
  logic ack, fmt_k = 0, rp_k = 0, play_k = 0, stop_k = 0, pun_k = 0;
  logic setl = 0, present = 0, tab = 1, ld = 0, fmt, bot;
  logic x_play, x_rew, x_rec, r441, fled, pled, rled, fo;
  logic [7:0] arm_k = 8'h0, ovw, aen, tled;
  logic [1:0] fsw = 2'h1, fsp, sec;
  int fails = 0, samples_checked = 0;

  always #5 clk_i = ~clk_i;

  tfc_top #(.SPS_48(1), .SPS_441(1), .SPINUP_CYCS(20)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .format_key_i(fmt_k),
    .record_play_i(rp_k), .play_key_i(play_k), .stop_key_i(stop_k),
    .punch_out_i(pun_k), .set_locate_i(setl), .track_arm_key_i(arm_k),
    .tape_present_i(present), .tape_tab_i(tab), .tape_formatted_i(fmt),
    .tape_at_bot_i(bot), .tape_at_eot_i(1'b0), .tape_tc_valid_i(fmt),
    .tape_tc_i(ttc), .transport_footswitch_input_i(fsw),
    .footswitch_press_o(fsp), .xport_play_o(x_play), .xport_rew_o(x_rew),
    .xport_rec_o(x_rec), .wr_section_o(sec), .wr_tc_o(wtc),
    .wr_rate_441_o(r441), .trk_overwrite_o(ovw), .trk_audio_en_o(aen),
    .track_armed_led_o(tled), .format_led_o(fled), .protect_led_o(pled),
    .rew_led_o(rled), .reformat_display_code_o(fo));

  tfc_tape_model tape_u (
    .clk_i(clk_i), .rst_i(rst_i), .play_i(x_play), .rew_i(x_rew),
    .rec_i(x_rec), .ld_i(ld), .ld_pos_i(ld_pos), .fmt_lo_i(lo),
    .fmt_hi_i(hi), .zero_i(zero), .fmt_o(fmt), .bot_o(bot), .tc_o(ttc));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task hang;
    fails++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test;
  endtask

  // Classic cycle: hold until ack, take data, then idle one cycle
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) hang;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task wait_st(input logic [2:0] s, input int lim);
    logic [31:0] q;
    int n;
    for (n = 0; n < lim; n++) begin
      wb(1'b0, ADDR_STAT, 32'h0, q);
      if (q[2:0] === s) break;
    end
    if (n == lim) hang;
  endtask

  // Codes: 0 format, 1 record, 2 play, 3 stop, 4 punch, 8+n arm key n
  task key(input int k);
    @(posedge clk_i);
    case (k)
      0: fmt_k <= 1'b1;
      1: rp_k <= 1'b1;
      2: play_k <= 1'b1;
      3: stop_k <= 1'b1;
      4: pun_k <= 1'b1;
      default: arm_k <= 8'(1 << (k - 8));
    endcase
    @(posedge clk_i);
    {fmt_k, rp_k, play_k, stop_k, pun_k} <= 5'h0;
    arm_k <= 8'h0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task load(input int p, input int l, input int h, input int z);
    ld <= 1'b1;
    ld_pos <= p;
    lo <= l;
    hi <= h;
    zero <= z;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    logic [31:0] q;
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check(q & 32'hFF, 32'h40);
    wb(1'b0, ADDR_CTRL, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h1, q);
    wb(1'b0, ADDR_CTRL, 32'h0, q);
    check(q, 32'h1);
    wb(1'b1, 4'hC, 32'hFFFFFFFF, q);
    wb(1'b0, 4'hC, 32'h0, q);
    check(q, 32'h0);
  endtask

  task t_fsw;
    @(negedge clk_i);
    check(32'(fsp), 32'h0);
    @(posedge clk_i);
    fsw <= 2'h2;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check(32'(fsp), 32'h3);
    @(posedge clk_i);
    fsw <= 2'h1;
  endtask

  task t_prot;
    logic [31:0] q;
    tab <= 1'b0;
    present <= 1'b1;
    key(0);
    check(32'(pled), 32'h1);
    @(posedge clk_i);
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check(q & 32'h107, 32'h100);
    setl <= 1'b1;
    key(8);
    @(posedge clk_i);
    setl <= 1'b0;
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check(32'(q[STAT_OVR]), 32'h1);
    check(32'(pled), 32'h0);
    present <= 1'b0;
    repeat (2) @(posedge clk_i);
    present <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check(32'(q[STAT_OVR]), 32'h0);
    present <= 1'b0;
    tab <= 1'b1;
    repeat (2) @(posedge clk_i);
    present <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  task t_complete;
    load(0, 0, 0, 0);
    key(0);
    check(32'(fled), 32'h1);
    key(1);
    check(32'(x_play), 32'h1);
    @(posedge clk_i);
    wait_st(3'h5, 30);
    check({sec, x_rec, ovw, aen}, {2'h1, 1'b1, 8'hFF, 8'h0});
    key(4);
    check(32'(sec), 32'h1);
    @(posedge clk_i);
    wait_st(3'h6, 15000);
    check(32'({sec, r441}), 32'h5);
    key(3);
    check(32'({sec, x_rec}), 32'h0);
    @(posedge clk_i);
  endtask

  task t_reform;
    load(1000, 0, 100000, 5000);
    key(0);
    key(1);
    @(posedge clk_i);
    wait_st(3'h4, 30);
    check(32'({fo, x_rew}), 32'h3);
    wait_st(3'h5, 1000);
    check(32'(sec), 32'h1);
    key(3);
    @(posedge clk_i);
  endtask

  task t_unfmt;
    load(2000, 0, 300, 0);
    key(0);
    key(1);
    @(posedge clk_i);
    wait_st(3'h3, 30);
    check(32'({fo, rled}), 32'h1);
    wait_st(3'h1, 1500);
    check(32'(x_rew), 32'h0);
    key(3);
    @(posedge clk_i);
  endtask

  task t_extend;
    logic [31:0] v;
    int n;
    load(1000, 0, 100000, 50);
    key(11);
    key(0);
    key(13);
    key(2);
    @(posedge clk_i);
    for (n = 0; n < 100 && sec !== 2'h3; n++) @(negedge clk_i);
    if (n == 100) hang;
    check(wtc, 32'd950);
    check({sec, ovw, aen}, {2'h3, 8'hFF, 8'h08});
    v = wtc;
    for (n = 0; n < 5000 && wtc === v; n++) @(negedge clk_i);
    check(wtc, v + 32'h1);
    @(posedge clk_i);
    key(3);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_fsw;
    t_prot;
    t_complete;
    t_reform;
    t_unfmt;
    t_extend;
    finish_test;
  end
endmodule
